// File: core/vlm_pkg.sv
// vlm_pkg: constants and types for the output limit and margin registers
package vlm_pkg;
  // ----------------------------------------
  // link addressing and command codes
  // ----------------------------------------
  localparam logic [6:0] BUS_ADDR = 7'h40;
  localparam logic [7:0] CMD_UPPER = 8'h24;
  localparam logic [7:0] CMD_MARGH = 8'h25;
  localparam logic [7:0] CMD_MARGL = 8'h26;
  localparam logic [7:0] CMD_SLEW = 8'h27;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  localparam logic [2:0] IDX_ADDR = 3'h0;
  localparam logic [2:0] IDX_CMD = 3'h1;
  localparam logic [2:0] IDX_LO = 3'h2;
  localparam logic [2:0] IDX_HI = 3'h3;
  localparam logic [2:0] IDX_OVER = 3'h4;
  // ----------------------------------------
  // field layout and reset values
  // ----------------------------------------
  localparam int EXP_MSB = 15;
  localparam int EXP_LSB = 11;
  localparam int MAN_MSB = 10;
  localparam logic [4:0] SLEW_EXP_RST = 5'h1C;
  localparam logic signed [5:0] RATE_EXP_BIAS = 6'sh04;
  localparam logic [8:0] RATE_MIN = 9'h001;
  localparam logic [8:0] RATE_MAX = 9'h0FF;
  localparam logic [1:0] MARG_LOW = 2'h1;
  localparam logic [1:0] MARG_HIGH = 2'h2;
  localparam logic [15:0] DAC_MAX_CODE = 16'h1800;
  // ----------------------------------------
  // slew timing
  // ----------------------------------------
  localparam int CLK_FREQ_MHZ = 100;
  localparam int RATE_LSB_NV_PER_US = 62500;
  localparam int VOUT_LSB_NV = 244141;
  localparam int UNITS_PER_LSB = (VOUT_LSB_NV + RATE_LSB_NV_PER_US / 2) / RATE_LSB_NV_PER_US;
  localparam logic [9:0] STEP_COST = 10'(CLK_FREQ_MHZ * UNITS_PER_LSB);
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX = 3'h1,
    ST_ACK = 3'h3,
    ST_TX = 3'h2,
    ST_RACK = 3'h6
  } vlm_state_t;
  typedef struct packed {
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } vlm_link_ev_t;
  typedef struct packed {
    logic limit_warn;
    logic none_above;
    logic word_vout;
    logic cml_invalid;
  } vlm_status_t;
  typedef struct packed {
    logic stb;
    logic [7:0] cmd;
    logic [15:0] data;
  } vlm_wr_t;
endpackage

// File: core/vlm_link_front.sv
// vlm_link_front: pin synchronisers and bus condition detection
`timescale 1ns/1ps
module vlm_link_front (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output vlm_pkg::vlm_link_ev_t ev_out
);
  import vlm_pkg::*;

  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic scl_prev_r;
  logic sda_prev_r;
  vlm_link_ev_t ev_r;

  // ----------------------------------------
  // two-stage synchronisers
  // ----------------------------------------
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
    end
    else
    begin
      scl_sync_r <= {scl_sync_r[0], scl_in};
      sda_sync_r <= {sda_sync_r[0], sda_in};
    end
  end

  // ----------------------------------------
  // edge and start/stop detection
  // ----------------------------------------
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
      ev_r <= '0;
    end
    else
    begin
      scl_prev_r <= scl_sync_r[1];
      sda_prev_r <= sda_sync_r[1];
      ev_r.sda <= sda_sync_r[1];
      ev_r.scl_rise <= scl_sync_r[1] & ~scl_prev_r;
      ev_r.scl_fall <= ~scl_sync_r[1] & scl_prev_r;
      // sda moving while scl high marks start or stop
      ev_r.start <= scl_sync_r[1] & scl_prev_r & sda_prev_r & ~sda_sync_r[1];
      ev_r.stop <= scl_sync_r[1] & scl_prev_r & ~sda_prev_r & sda_sync_r[1];
    end
  end

  assign ev_out = ev_r;
endmodule // vlm_link_front

// File: core/vlm_regs.sv
// vlm_regs: upper limit, margin and slew registers with target clamp
`timescale 1ns/1ps
module vlm_regs (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [15:0] nvm_upper_in,
  input wire logic [15:0] nvm_margh_in,
  input wire logic [15:0] nvm_margl_in,
  input wire logic [10:0] nvm_slew_man_in,
  input wire logic [15:0] nominal_cmd_in,
  input wire logic [15:0] trim_in,
  input wire logic [15:0] lower_limit_in,
  input wire logic [1:0] margin_sel_in,
  input wire logic conv_en_in,
  input wire logic clear_faults_in,
  output logic [15:0] ref_out,
  output logic [8:0] slew_rate_out,
  output vlm_pkg::vlm_status_t status_out,
  output logic alert_n_out
);
  import vlm_pkg::*;

  vlm_link_ev_t ev;
  vlm_state_t st_r;
  logic [3:0] bitc_r;
  logic [2:0] bidx_r;
  logic [7:0] shreg_r;
  logic [7:0] lo_r;
  logic [7:0] tx_r;
  logic [7:0] cmd_r;
  logic cmd_ok_r;
  logic rw_r;
  logic tx_hi_r;
  logic sda_oe_r;
  logic sda_lvl_r;
  vlm_wr_t wr_r;
  logic [15:0] upper_r;
  logic [15:0] margh_r;
  logic [15:0] margl_r;
  logic [15:0] slew_r;
  logic [8:0] rate_r;
  logic [15:0] ref_r;
  logic [9:0] acc_r;
  logic [9:0] acc_nxt;
  logic signed [17:0] sum_prev_r;
  logic [15:0] upper_prev_r;
  logic [15:0] lower_prev_r;
  vlm_status_t stat_r;
  logic alert_n_r;
  logic byte_ack_c;
  logic [15:0] rd_word_c;
  logic [15:0] base_c;
  logic signed [17:0] sum_c;
  logic hi_c;
  logic lo_c;
  logic chg_c;
  logic warn_ev_c;
  logic [15:0] goal_c;
  logic signed [17:0] cand_c;
  logic marg_ok_c;
  logic [8:0] new_rate_c;
  logic rate_ok_c;
  logic inval_ev_c;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic cmd_known(input logic [7:0] c);
    return (c == CMD_UPPER) || (c == CMD_MARGH) || (c == CMD_MARGL) || (c == CMD_SLEW);
  endfunction

  function automatic logic signed [17:0] eff_sum(input logic [15:0] base,
                                                 input logic [15:0] trim);
    return $signed({2'h0, base}) + $signed({{2{trim[15]}}, trim});
  endfunction

  // rate in 1/16 mV/us steps, 256 means out of range
  function automatic logic [8:0] rate_norm(input logic [15:0] w);
    logic signed [5:0] sh;
    logic [19:0] v;
    logic [5:0] amt;
    sh = $signed({w[EXP_MSB], w[EXP_MSB:EXP_LSB]}) + RATE_EXP_BIAS;
    amt = 6'(-sh);
    v = {9'h0, w[MAN_MSB:0]};
    if (w[MAN_MSB])
      v = '0;
    else if (sh >= 0)
      v = (sh > 6'sh09) ? ((v == '0) ? '0 : 20'hFFFFF) : (v << sh[3:0]);
    else
      v = (v + (20'h1 << (amt - 6'h1))) >> amt;
    return (v > {11'h0, RATE_MAX}) ? 9'h100 : v[8:0];
  endfunction

  // ----------------------------------------
  // link front end
  // ----------------------------------------
  vlm_link_front u_front (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .ev_out(ev)
  );

  // ----------------------------------------
  // byte decode
  // ----------------------------------------
  always_comb
  begin
    unique case (bidx_r)
      IDX_ADDR: byte_ack_c = (shreg_r[7:1] == BUS_ADDR) && (!shreg_r[0] || cmd_ok_r);
      IDX_CMD: byte_ack_c = cmd_known(shreg_r);
      IDX_LO, IDX_HI: byte_ack_c = !rw_r;
      default: byte_ack_c = 1'b0;
    endcase
  end

  always_comb
  begin
    case (cmd_r)
      CMD_UPPER: rd_word_c = upper_r;
      CMD_MARGH: rd_word_c = margh_r;
      CMD_MARGL: rd_word_c = margl_r;
      default: rd_word_c = slew_r;
    endcase
  end

  // ----------------------------------------
  // word read/write link engine
  // ----------------------------------------
  // word transactions
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      st_r <= ST_IDLE;
      bitc_r <= '0;
      bidx_r <= IDX_ADDR;
      shreg_r <= '0;
      lo_r <= '0;
      tx_r <= '0;
      cmd_r <= '0;
      cmd_ok_r <= 1'b0;
      rw_r <= 1'b0;
      tx_hi_r <= 1'b0;
      sda_oe_r <= 1'b0;
      wr_r <= '0;
    end
    else
    begin
      wr_r.stb <= 1'b0;
      if (ev.start)
      begin
        st_r <= ST_RX;
        bitc_r <= '0;
        bidx_r <= IDX_ADDR;
        sda_oe_r <= 1'b0;
      end
      else if (ev.stop)
      begin
        st_r <= ST_IDLE;
        sda_oe_r <= 1'b0;
      end
      else
      begin
        unique case (st_r)
          ST_IDLE:
          begin
          end
          ST_RX:
          begin
            if (ev.scl_rise)
            begin
              shreg_r <= {shreg_r[6:0], ev.sda};
              bitc_r <= bitc_r + 4'h1;
            end
            else if (ev.scl_fall && bitc_r == BITS_PER_BYTE)
            begin
              bitc_r <= '0;
              bidx_r <= (bidx_r == IDX_OVER) ? IDX_OVER : bidx_r + 3'h1;
              sda_oe_r <= byte_ack_c;
              st_r <= byte_ack_c ? ST_ACK : ST_IDLE;
              if (bidx_r == IDX_ADDR)
                rw_r <= shreg_r[0];
              if (bidx_r == IDX_CMD)
              begin
                cmd_r <= shreg_r;
                cmd_ok_r <= cmd_known(shreg_r);
              end
              if (bidx_r == IDX_LO)
                lo_r <= shreg_r;
              if (bidx_r == IDX_HI && !rw_r)
              begin
                wr_r.stb <= 1'b1;
                wr_r.cmd <= cmd_r;
                wr_r.data <= {shreg_r, lo_r};
              end
            end
          end
          ST_ACK:
          begin
            if (ev.scl_fall)
            begin
              bitc_r <= '0;
              if (rw_r)
              begin
                // low byte first, open drain pulls only zeros
                tx_r <= rd_word_c[7:0];
                tx_hi_r <= 1'b0;
                sda_oe_r <= ~rd_word_c[7];
                st_r <= ST_TX;
              end
              else
              begin
                sda_oe_r <= 1'b0;
                st_r <= ST_RX;
              end
            end
          end
          ST_TX:
          begin
            if (ev.scl_fall)
            begin
              if (bitc_r == LAST_TX_BIT)
              begin
                sda_oe_r <= 1'b0;
                st_r <= ST_RACK;
              end
              else
              begin
                bitc_r <= bitc_r + 4'h1;
                tx_r <= {tx_r[6:0], 1'b0};
                sda_oe_r <= ~tx_r[6];
              end
            end
          end
          ST_RACK:
          begin
            if (ev.scl_rise)
              shreg_r <= {shreg_r[6:0], ev.sda};
            else if (ev.scl_fall)
            begin
              bitc_r <= '0;
              if (!shreg_r[0] && !tx_hi_r)
              begin
                tx_r <= rd_word_c[15:8];
                tx_hi_r <= 1'b1;
                sda_oe_r <= ~rd_word_c[15];
                st_r <= ST_TX;
              end
              else
                st_r <= ST_IDLE;
            end
          end
          default: st_r <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // write checks
  // ----------------------------------------
  // margin plus trim
  assign cand_c = eff_sum(wr_r.data, trim_in);
  assign marg_ok_c = (cand_c >= 0) && (cand_c <= $signed({2'h0, DAC_MAX_CODE}));
  assign new_rate_c = rate_norm(wr_r.data);
  assign rate_ok_c = (new_rate_c >= RATE_MIN) && (new_rate_c <= RATE_MAX);
  assign inval_ev_c = wr_r.stb && ((((wr_r.cmd == CMD_MARGH) || (wr_r.cmd == CMD_MARGL))
                      && !marg_ok_c) || ((wr_r.cmd == CMD_SLEW) && !rate_ok_c));

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      upper_r <= nvm_upper_in;
      margh_r <= nvm_margh_in;
      margl_r <= nvm_margl_in;
      slew_r <= {SLEW_EXP_RST, nvm_slew_man_in};
      rate_r <= rate_norm({SLEW_EXP_RST, nvm_slew_man_in});
    end
    else if (wr_r.stb)
    begin
      case (wr_r.cmd)
        CMD_UPPER: upper_r <= wr_r.data;
        CMD_MARGH: if (marg_ok_c) margh_r <= wr_r.data;
        CMD_MARGL: if (marg_ok_c) margl_r <= wr_r.data;
        CMD_SLEW:
        begin
          if (rate_ok_c)
          begin
            slew_r <= wr_r.data;
            rate_r <= new_rate_c;
          end
        end
        default:
        begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // effective target and limit check
  // ----------------------------------------
  // margin high/low or nominal select
  assign base_c = (margin_sel_in == MARG_HIGH) ? margh_r :
                  (margin_sel_in == MARG_LOW) ? margl_r : nominal_cmd_in;
  assign sum_c = eff_sum(base_c, trim_in);
  assign hi_c = sum_c > $signed({2'h0, upper_r});
  assign lo_c = sum_c < $signed({2'h0, lower_limit_in});
  assign chg_c = (sum_c != sum_prev_r) || (upper_r != upper_prev_r)
                 || (lower_limit_in != lower_prev_r);
  assign warn_ev_c = conv_en_in && (hi_c || lo_c) && chg_c;
  assign goal_c = hi_c ? upper_r : lo_c ? lower_limit_in : sum_c[15:0];

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      sum_prev_r <= '0;
      upper_prev_r <= '0;
      lower_prev_r <= '0;
    end
    else
    begin
      sum_prev_r <= sum_c;
      upper_prev_r <= upper_r;
      lower_prev_r <= lower_limit_in;
    end
  end

  // ----------------------------------------
  // slew engine
  // ----------------------------------------
  // fractional accumulator: rate/STEP_COST code steps per cycle
  assign acc_nxt = acc_r + {1'b0, rate_r};

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      ref_r <= '0;
      acc_r <= '0;
    end
    else if (!conv_en_in)
    begin
      ref_r <= goal_c;
      acc_r <= '0;
    end
    else if (ref_r == goal_c)
      acc_r <= '0;
    else if (acc_nxt >= STEP_COST)
    begin
      acc_r <= acc_nxt - STEP_COST;
      ref_r <= (goal_c > ref_r) ? ref_r + 16'h1 : ref_r - 16'h1;
    end
    else
      acc_r <= acc_nxt;
  end

  // ----------------------------------------
  // status and alert
  // ----------------------------------------
  // set wins over clear on the same edge
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
      stat_r <= '0;
    else
    begin
      if (warn_ev_c)
      begin
        stat_r.limit_warn <= 1'b1;
        stat_r.none_above <= 1'b1;
        stat_r.word_vout <= 1'b1;
      end
      else if (clear_faults_in)
      begin
        stat_r.limit_warn <= 1'b0;
        stat_r.word_vout <= 1'b0;
      end
      if (warn_ev_c || inval_ev_c)
        stat_r.none_above <= 1'b1;
      else if (clear_faults_in)
        stat_r.none_above <= 1'b0;
      if (inval_ev_c)
        stat_r.cml_invalid <= 1'b1;
      else if (clear_faults_in)
        stat_r.cml_invalid <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      alert_n_r <= 1'b1;
      sda_lvl_r <= 1'b0;
    end
    else
    begin
      alert_n_r <= ~(stat_r.limit_warn | stat_r.cml_invalid);
      sda_lvl_r <= 1'b0;
    end
  end

  assign sda_out = sda_lvl_r;
  assign sda_oe_out = sda_oe_r;
  assign ref_out = ref_r;
  assign slew_rate_out = rate_r;
  assign status_out = stat_r;
  assign alert_n_out = alert_n_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_alert_tail;
    ##1 stat_r.limit_warn ##1 !alert_n_r;
  endsequence
  property p_status_set;
    warn_ev_c |=> stat_r.limit_warn && stat_r.none_above && stat_r.word_vout;
  endproperty
  a_status_set: assert property (p_status_set) else $error("status not set");
  property p_alert;
    warn_ev_c |-> s_alert_tail;
  endproperty
  a_alert: assert property (p_alert) else $error("alert not raised");
  property p_clamp_hi;
    conv_en_in && hi_c && (ref_r < upper_r) |=> ref_r <= $past(upper_r);
  endproperty
  a_clamp_hi: assert property (p_clamp_hi) else $error("ramp passed limit");
  property p_slew_step;
    conv_en_in && $past(conv_en_in) |-> (ref_r == $past(ref_r)) ||
      (ref_r == $past(ref_r) + 16'h1) || (ref_r == $past(ref_r) - 16'h1);
  endproperty
  a_slew_step: assert property (p_slew_step) else $error("step too large");
  property p_off_direct;
    !conv_en_in |=> ref_r == $past(goal_c);
  endproperty
  a_off_direct: assert property (p_off_direct) else $error("ramp while off");
  property p_upper_wr;
    wr_r.stb && (wr_r.cmd == CMD_UPPER) |=> upper_r == $past(wr_r.data);
  endproperty
  a_upper_wr: assert property (p_upper_wr) else $error("upper not stored");
  property p_marg_bad;
    wr_r.stb && (wr_r.cmd == CMD_MARGH) && !marg_ok_c |=>
      stat_r.cml_invalid && $stable(margh_r);
  endproperty
  a_marg_bad: assert property (p_marg_bad) else $error("bad margin taken");
  property p_rate_bad;
    wr_r.stb && (wr_r.cmd == CMD_SLEW) && !rate_ok_c |=>
      $stable(slew_r) && stat_r.cml_invalid;
  endproperty
  a_rate_bad: assert property (p_rate_bad) else $error("bad rate taken");
  property p_upper_low;
    wr_r.stb && (wr_r.cmd == CMD_UPPER) && conv_en_in
      && ($signed({2'h0, wr_r.data}) < sum_c) |=> !conv_en_in || !hi_c || warn_ev_c;
  endproperty
  a_upper_low: assert property (p_upper_low) else $error("no warn on low limit");
endmodule // vlm_regs

// File: bench/vlm_host_model.sv
// vlm_host_model: bus host issuing word writes and word reads
`timescale 1ns/1ps
module vlm_host_model (
  output logic scl_out,
  output logic sda_oe_out,
  input wire logic sda_in
);
  import vlm_pkg::*;
  logic [7:0] rx;
  logic a;
  initial
  begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end
  // ----------------------------------------
  // bit and byte level, 125 ns bus clock
  // ----------------------------------------
  // data moves only mid-low, so no false start or stop
  task automatic bit_io(input logic b, output logic r);
    #31.25 sda_oe_out = ~b;
    #31.25 scl_out = 1'b1;
    #62.5 r = sda_in;
    scl_out = 1'b0;
  endtask
  task automatic put(input logic [7:0] d, input logic drv, input logic chk, inout logic ok);
    if (ok)
    begin
      for (int i = 7; i >= 0; i--)
        bit_io(d[i], rx[i]);
      bit_io(drv, a);
      if (chk)
        ok = ~a;
    end
  endtask
  task automatic start;
    #31.25 sda_oe_out = 1'b1;
    #31.25 scl_out = 1'b0;
  endtask
  // release waits past the device's ack hold
  task automatic restart;
    #31.25 sda_oe_out = 1'b0;
    #31.25 scl_out = 1'b1;
    #31.25 sda_oe_out = 1'b1;
    #31.25 scl_out = 1'b0;
  endtask
  task automatic stop;
    #31.25 sda_oe_out = 1'b1;
    #31.25 scl_out = 1'b1;
    #31.25 sda_oe_out = 1'b0;
    #62.5;
  endtask
  task automatic write_word(input logic [7:0] c, input logic [15:0] d, output logic ok);
    ok = 1'b1;
    // offset keeps pin edges clear of mclk edges
    #2;
    start();
    put({BUS_ADDR, 1'b0}, 1'b1, 1'b1, ok);
    put(c, 1'b1, 1'b1, ok);
    put(d[7:0], 1'b1, 1'b1, ok);
    put(d[15:8], 1'b1, 1'b1, ok);
    stop();
  endtask
  // read word, nack ends the high byte
  task automatic read_word(input logic [7:0] c, output logic [15:0] d, output logic ok);
    ok = 1'b1;
    // offset keeps pin edges clear of mclk edges
    #2;
    start();
    put({BUS_ADDR, 1'b0}, 1'b1, 1'b1, ok);
    put(c, 1'b1, 1'b1, ok);
    if (ok)
      restart();
    put({BUS_ADDR, 1'b1}, 1'b1, 1'b1, ok);
    put(8'hFF, 1'b0, 1'b0, ok);
    d[7:0] = rx;
    put(8'hFF, 1'b1, 1'b0, ok);
    d[15:8] = rx;
    stop();
  endtask
endmodule // vlm_host_model

// File: bench/tb_top.sv
// tb_top: self-checking bench for the limit and margin register block
`timescale 1ns/1ps
module tb_top;
  import vlm_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic conv_en_in = 1'b0;
  logic clr = 1'b0;
  logic scl, host_oe, sda_out, sda_oe_out, alert_n_out, ok;
  logic [15:0] nominal = 16'h0800;
  logic [15:0] trim = 16'h0000;
  logic [15:0] lower = 16'h0100;
  logic [15:0] ref_out, rd;
  logic [1:0] msel = 2'h0;
  logic [8:0] slew_rate_out;
  vlm_status_t status_out;
  int fails = 0;
  int checks_done = 0;
  int n;
  // pull-up: low while either party pulls
  wire sda = ~host_oe & (~sda_oe_out | sda_out);
  always #5 mclk_in = ~mclk_in;
  vlm_host_model u_vlm_host_model (.scl_out(scl), .sda_oe_out(host_oe), .sda_in(sda));
  vlm_regs u_vlm_regs (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .nvm_upper_in(16'h1000), .nvm_margh_in(16'h0A00), .nvm_margl_in(16'h0600),
    .nvm_slew_man_in(11'h0FF), .nominal_cmd_in(nominal), .trim_in(trim),
    .lower_limit_in(lower), .margin_sel_in(msel), .conv_en_in(conv_en_in),
    .clear_faults_in(clr), .ref_out(ref_out), .slew_rate_out(slew_rate_out),
    .status_out(status_out), .alert_n_out(alert_n_out));
  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge mclk_in);
  endtask
  // ramp is slow, so wait is bounded per scenario
  task automatic wait_ref(input logic [15:0] exp, input int lim);
    n = 0;
    while (ref_out !== exp && n < lim)
    begin
      @(negedge mclk_in);
      n++;
    end
    chk("ref", exp, ref_out);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic exp_ok);
    u_vlm_host_model.write_word(c, d, ok);
    cyc(4);
    chk("write ack", {15'h0, exp_ok}, {15'h0, ok});
  endtask
  task automatic rd_chk(input logic [7:0] c, input logic [15:0] exp);
    u_vlm_host_model.read_word(c, rd, ok);
    cyc(2);
    chk("read ack", 16'h0001, {15'h0, ok});
    chk("read data", exp, rd);
  endtask
  task automatic warn_chk(input logic [3:0] exp);
    cyc(4);
    chk("status", {12'h0, exp}, {12'h0, status_out});
    chk("alert_n", {15'h0, ~exp[2]}, {15'h0, alert_n_out});
  endtask
  task automatic clear;
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    warn_chk(4'h0);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk("ref", 16'h0800, ref_out);
    chk("rate", 16'h00FF, {7'h0, slew_rate_out});
    warn_chk(4'h0);
    rd_chk(CMD_UPPER, 16'h1000);
    rd_chk(CMD_MARGH, 16'h0A00);
    rd_chk(CMD_MARGL, 16'h0600);
    rd_chk(CMD_SLEW, {5'h1C, 11'h0FF});
  endtask
  task automatic t_rw;
    wr(CMD_UPPER, 16'h1400, 1'b1);
    wr(CMD_MARGH, 16'h0C00, 1'b1);
    wr(CMD_MARGL, 16'h0500, 1'b1);
    wr(CMD_SLEW, 16'hE080, 1'b1);
    wr(8'h28, 16'h1234, 1'b0);
    rd_chk(CMD_UPPER, 16'h1400);
    rd_chk(CMD_MARGH, 16'h0C00);
    rd_chk(CMD_MARGL, 16'h0500);
    rd_chk(CMD_SLEW, 16'hE080);
    chk("rate", 16'h0080, {7'h0, slew_rate_out});
  endtask
  task automatic t_margin;
    conv_en_in = 1'b1;
    cyc(2);
    trim = 16'h0010;
    wait_ref(16'h0810, 100);
    msel = MARG_HIGH;
    wait_ref(16'h0C10, 4000);
    // 1024 codes at 128 units, 400 units a code
    chk("ramp", 16'h0001, {15'h0, n > 3190 && n < 3215});
    msel = MARG_LOW;
    wait_ref(16'h0510, 6000);
    msel = 2'h0;
    wait_ref(16'h0810, 3000);
    warn_chk(4'h0);
  endtask
  task automatic t_warn;
    nominal = 16'h1500;
    warn_chk(4'hE);
    wait_ref(16'h1400, 12000);
    clear();
  endtask
  task automatic t_limit;
    nominal = 16'h1300;
    wait_ref(16'h1310, 2000);
    warn_chk(4'h0);
    wr(CMD_UPPER, 16'h1200, 1'b1);
    warn_chk(4'hE);
    wait_ref(16'h1200, 1000);
    rd_chk(CMD_UPPER, 16'h1200);
    clear();
  endtask
  task automatic t_lower;
    nominal = 16'h0080;
    warn_chk(4'hE);
    wait_ref(16'h0100, 15000);
    clear();
  endtask
  task automatic t_invalid;
    wr(CMD_MARGH, 16'h1900, 1'b1);
    warn_chk(4'h5);
    rd_chk(CMD_MARGH, 16'h0C00);
    clear();
    wr(CMD_SLEW, 16'hE000, 1'b1);
    warn_chk(4'h5);
    chk("rate", 16'h0080, {7'h0, slew_rate_out});
    clear();
  endtask
  task automatic t_off;
    conv_en_in = 1'b0;
    cyc(2);
    nominal = 16'h0400;
    cyc(2);
    chk("ref", 16'h0410, ref_out);
    warn_chk(4'h0);
  endtask
  // mid-run reset must reload the stored values over written ones
  task automatic t_rst;
    rst_n_in = 1'b0;
    cyc(6);
    rst_n_in = 1'b1;
    cyc(4);
    chk("rate", 16'h00FF, {7'h0, slew_rate_out});
    rd_chk(CMD_UPPER, 16'h1000);
    rd_chk(CMD_MARGH, 16'h0A00);
    rd_chk(CMD_SLEW, {5'h1C, 11'h0FF});
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    cyc(6);
    rst_n_in = 1'b1;
    cyc(4);
    t_reset();
    t_rw();
    t_margin();
    t_warn();
    t_limit();
    t_lower();
    t_invalid();
    t_off();
    t_rst();
    finish_test();
  end
  // whole run is near 480 us; cut off at 800 us, under 100k cycles
  initial
  begin
    #800000;
    fails++;
    finish_test();
  end
endmodule // tb_top
